// ### src/thermal_throttle_pin_assert_timer.sv
// Thermal-throttle assertion timer, time limit and fan pulse-count settings.
//
// Behaviour
// R1: Status bit zero sets on throttle assertion and clears when status is read.
// R2: Beyond 45.52 ms bit zero becomes the timer reading's least significant bit.
// R3: Assertion time is reported in 22.76 ms steps, up to 5.80 s.
// R4: Upper seven status bits read zero until time exceeds 45.52 ms.
// R5: Writable eight-bit time limit, each count worth 22.76 ms.
// R6: Time beyond the limit raises the overtemperature timer interrupt flag.
// R7: A zero limit raises the flag immediately on throttle assertion.
// R8: Software should set the limit to 0xFF when the pin is an output.
// R9: Each two-bit fan code selects one to four tachometer pulses.
// R10: Fan one to four codes sit in bits 1:0, 3:2, 5:4, 7:6.
// R11: Pulse register resets to 0x55; status and limit reset to 0x00.
// R12: The time counter runs only while asserted and saturates at maximum.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_throttle_pin_timer_params.svh"

module thermal_throttle_pin_assert_timer
    import thermal_throttle_pin_timer_pkg::*;
#(
    parameter int TICK_CYCLES = `TT_TICK_CYCLES
)
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Thermal-throttle input, low while asserted.
    input wire logic thermal_throttle_pin_n_i,
    // Register port from the serial interface.
    input wire reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    // One-cycle request to set the interrupt status bit.
    output logic overtemp_timer_interrupt_flag_o,
    // Tachometer pulses counted per measurement, per fan.
    output fan_pulses_t fan_pulses_o
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Maps a two-bit code to a pulse count of one to four.
    function automatic logic [2:0] pulses_for(input logic [1:0] code);
        pulses_for = {1'b0, code} + 3'h1;
    endfunction : pulses_for

    function automatic logic [7:0] status_view(input logic [7:0] cnt, input logic flg);
        logic [7:0] v;
        v = cnt;
        if (cnt < `TT_LSB_STEPS)
        begin
            v = {7'h00, flg};
        end
        status_view = v;
    endfunction : status_view

    // ************************************************************
    // State
    // ************************************************************

    logic [19:0] presc;
    logic [19:0] next_presc;
    logic [7:0] assert_time_count;
    logic [7:0] next_assert_time_count;
    logic assert_flag_timer_lsb;
    logic next_assert_flag_timer_lsb;
    logic [7:0] assert_time_limit;
    logic [7:0] next_assert_time_limit;
    logic [7:0] pulse_sel;
    logic [7:0] next_pulse_sel;
    logic pin_prev_n;
    logic [7:0] next_rdata;
    logic next_irq;
    fan_pulses_t next_fan_pulses;

    logic asserted;
    logic rise;
    logic tick;
    logic rd_status;

    assign asserted = ~thermal_throttle_pin_n_i;
    assign rise = asserted & pin_prev_n;
    assign tick = asserted && (presc == 20'(TICK_CYCLES - 1));
    assign rd_status = reg_req_i.rd && (reg_req_i.addr == `TT_ADDR_STATUS);

    // ************************************************************
    // Next-state logic
    // ************************************************************

    always_comb
    begin
        next_presc = presc;
        next_assert_time_count = assert_time_count;
        next_assert_flag_timer_lsb = assert_flag_timer_lsb;
        next_assert_time_limit = assert_time_limit;
        next_pulse_sel = pulse_sel;
        next_rdata = reg_rdata_o;
        next_irq = 1'b0;

        if (rd_status)
        begin
            next_presc = 20'h00000;
            next_assert_time_count = 8'h00;
            next_assert_flag_timer_lsb = 1'b0;
        end
        // R12: count while asserted
        if (asserted)
        begin
            next_presc = tick ? 20'h00000 : next_presc + 20'h00001;
        end
        // R3: one step per tick
        if (tick && next_assert_time_count != 8'hFF)
        begin
            next_assert_time_count = next_assert_time_count + 8'h01;
        end
        // R1: set wins over read clear
        if (rise)
        begin
            next_assert_flag_timer_lsb = 1'b1;
        end
        // R7: zero limit fires at once
        if (assert_time_limit == 8'h00)
        begin
            next_irq = rise;
        end
        // R6: time beyond limit
        // A saturated count can never pass a 0xFF limit, so it must not fire.
        else if (tick && assert_time_count == assert_time_limit && assert_time_count != 8'hFF)
        begin
            next_irq = 1'b1;
        end

        if (reg_req_i.rd)
        begin
            unique case (reg_req_i.addr)
                // R2: bit zero view
                // R4: upper bits gated
                `TT_ADDR_STATUS: next_rdata = status_view(assert_time_count,
                                                          assert_flag_timer_lsb);
                `TT_ADDR_LIMIT: next_rdata = assert_time_limit;
                `TT_ADDR_PULSES: next_rdata = pulse_sel;
                default: next_rdata = 8'h00;
            endcase
        end
        if (reg_req_i.wr)
        begin
            // R5: limit is writable
            if (reg_req_i.addr == `TT_ADDR_LIMIT)
            begin
                next_assert_time_limit = reg_req_i.wdata;
            end
            if (reg_req_i.addr == `TT_ADDR_PULSES)
            begin
                next_pulse_sel = reg_req_i.wdata;
            end
        end

        // R9: decode pulse counts
        // R10: fan field positions
        next_fan_pulses.first_fan_pulse_select = pulses_for(next_pulse_sel[1:0]);
        next_fan_pulses.second_fan_pulse_select = pulses_for(next_pulse_sel[3:2]);
        next_fan_pulses.third_fan_pulse_select = pulses_for(next_pulse_sel[5:4]);
        next_fan_pulses.fourth_fan_pulse_select = pulses_for(next_pulse_sel[7:6]);
    end

    // ************************************************************
    // Registers
    // ************************************************************

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            presc <= 20'h00000;
            // R11: power-on values
            assert_time_count <= `TT_RST_STATUS;
            assert_flag_timer_lsb <= 1'b0;
            assert_time_limit <= `TT_RST_LIMIT;
            pulse_sel <= `TT_RST_PULSES;
            pin_prev_n <= 1'b1;
            reg_rdata_o <= 8'h00;
            overtemp_timer_interrupt_flag_o <= 1'b0;
            fan_pulses_o <= {3'h2, 3'h2, 3'h2, 3'h2};
        end
        else
        begin
            presc <= next_presc;
            assert_time_count <= next_assert_time_count;
            assert_flag_timer_lsb <= next_assert_flag_timer_lsb;
            assert_time_limit <= next_assert_time_limit;
            pulse_sel <= next_pulse_sel;
            pin_prev_n <= thermal_throttle_pin_n_i;
            reg_rdata_o <= next_rdata;
            overtemp_timer_interrupt_flag_o <= next_irq;
            fan_pulses_o <= next_fan_pulses;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    flag_on_rise_a: assert property (rise |=> assert_flag_timer_lsb) // R1
        else $error("assertion flag not set on throttle assertion");
    read_clears_a: assert property (rd_status && !rise |=> !assert_flag_timer_lsb) // R1
        else $error("status read did not clear the flag");
    low_reading_a: assert property ( // R4
        reg_req_i.rd && reg_req_i.addr == `TT_ADDR_STATUS && assert_time_count < 8'h02
        |=> reg_rdata_o[7:1] == 7'h00)
        else $error("upper timer bits nonzero before two steps");
    lsb_reading_a: assert property ( // R2
        reg_req_i.rd && reg_req_i.addr == `TT_ADDR_STATUS && assert_time_count >= 8'h02
        |=> reg_rdata_o == $past(assert_time_count))
        else $error("timer reading wrong after two steps");
    idle_hold_a: assert property (!asserted && !rd_status |=> $stable(assert_time_count)) // R12
        else $error("timer moved while not asserted");
    saturate_a: assert property (assert_time_count == 8'hFF && !rd_status // R12
        |=> assert_time_count == 8'hFF)
        else $error("timer wrapped");
    step_tick_a: assert property (tick && !rd_status && assert_time_count != 8'hFF // R3
        |=> assert_time_count == $past(assert_time_count) + 8'h01)
        else $error("timer did not advance on a step");
    zero_limit_a: assert property (rise && assert_time_limit == 8'h00 // R7
        |=> overtemp_timer_interrupt_flag_o)
        else $error("zero limit did not raise the flag");
    over_limit_a: assert property ( // R6
        tick && assert_time_limit != 8'h00 && assert_time_count == assert_time_limit
        && assert_time_count != 8'hFF
        |=> overtemp_timer_interrupt_flag_o)
        else $error("flag missing when limit exceeded");
    max_limit_quiet_a: assert property (assert_time_limit == 8'hFF // R6
        |=> !overtemp_timer_interrupt_flag_o)
        else $error("interrupt raised with the limit at its maximum");
    limit_write_a: assert property (reg_req_i.wr && reg_req_i.addr == `TT_ADDR_LIMIT // R5
        |=> assert_time_limit == $past(reg_req_i.wdata))
        else $error("limit write lost");
    fan_one_a: assert property (fan_pulses_o.first_fan_pulse_select // R9
        == 3'(pulse_sel[1:0]) + 3'h1)
        else $error("fan one pulse count wrong");
    fan_four_a: assert property (fan_pulses_o.fourth_fan_pulse_select // R10
        == 3'(pulse_sel[7:6]) + 3'h1)
        else $error("fan four pulse count wrong");

endmodule : thermal_throttle_pin_assert_timer
`default_nettype wire

// ### src/thermal_throttle_pin_timer_params.svh
// Register offsets, reset values and timing counts of the thermal-throttle timer.
`ifndef THERMAL_THROTTLE_PIN_TIMER_PARAMS_SVH
`define THERMAL_THROTTLE_PIN_TIMER_PARAMS_SVH

`define TT_ADDR_STATUS 8'h79
`define TT_ADDR_LIMIT 8'h7A
`define TT_ADDR_PULSES 8'h7B

`define TT_RST_STATUS 8'h00
`define TT_RST_LIMIT 8'h00
`define TT_RST_PULSES 8'h55

`define TT_STEP_NS 22760000
`define TT_CLK_NS 25
`define TT_TICK_CYCLES (`TT_STEP_NS / `TT_CLK_NS)
`define TT_LSB_STEPS 8'h02

`endif

// ### src/thermal_throttle_pin_timer_pkg.sv
// Types shared by the thermal-throttle timer and its register port.
package thermal_throttle_pin_timer_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [2:0] fourth_fan_pulse_select;
        logic [2:0] third_fan_pulse_select;
        logic [2:0] second_fan_pulse_select;
        logic [2:0] first_fan_pulse_select;
    } fan_pulses_t;

endpackage : thermal_throttle_pin_timer_pkg

// ### tb/thermal_throttle_pin_assert_timer_tb.sv
// Self-checking bench for the thermal-throttle assertion timer.
`timescale 1ns/1ps
`default_nettype none

module thermal_throttle_pin_assert_timer_tb;
    import thermal_throttle_pin_timer_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start = 1'b0;
    logic [11:0] len = 12'h000;
    logic pin_n;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic irq;
    fan_pulses_t fans;
    int n_errors = 0;
    int checks = 0;
    int n_irq = 0;

    thermal_throttle_pin_assert_timer #(.TICK_CYCLES(4)) thermal_throttle_pin_assert_timer_i (.mclk_i(mclk_i),
        .rst_i(rst_i), .thermal_throttle_pin_n_i(pin_n), .reg_req_i(req),
        .reg_rdata_o(rdata), .overtemp_timer_interrupt_flag_o(irq), .fan_pulses_o(fans));
    throttle_source throttle_source_i (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start),
        .len_i(len), .thermal_throttle_pin_n_o(pin_n));

    initial forever #12.5 mclk_i = ~mclk_i;

    // Counts interrupt pulses; t_zero_limit, t_limit and t_saturate compare the growth over their own windows.
    always @(posedge mclk_i)
        if (irq === 1'b1)
            n_irq <= n_irq + 1;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic cmp(input string name, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge mclk_i);
        #2 req = '0;
        // An idle edge keeps a following call from re-raising the strobes in the same step.
        @(posedge mclk_i);
        #2;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 8'h00);
        cmp("rdata", {4'h0, exp}, {4'h0, rdata});
    endtask : rd

    task automatic throttle(input logic [11:0] n);
        int i;
        len = n;
        start = 1'b1;
        @(posedge mclk_i);
        #2 start = 1'b0;
        for (i = 0; i < 2000 && pin_n !== 1'b1; i++)
            @(posedge mclk_i) #2;
        if (pin_n !== 1'b1)
        begin
            cmp("pin_n", 12'h001, {11'h000, pin_n});
            end_sim();
        end
        repeat (3) @(posedge mclk_i);
        #2;
    endtask : throttle

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd(8'h79, 8'h00);
        rd(8'h7A, 8'h00);
        rd(8'h7B, 8'h55);
        rd(8'h7C, 8'h00);
        cmp("fans", {3'h2, 3'h2, 3'h2, 3'h2}, fans);
    endtask : t_reset

    task automatic t_pulses();
        bus(8'h7B, 1'b1, 8'h1B);
        @(posedge mclk_i) #2;
        cmp("fans", {3'h1, 3'h2, 3'h3, 3'h4}, fans);
        rd(8'h7B, 8'h1B);
    endtask : t_pulses

    task automatic t_zero_limit();
        int base;
        base = n_irq;
        throttle(12'd2);
        cmp("irq", 12'd1, 12'(n_irq - base));
        bus(8'h79, 1'b1, 8'hFF);
        rd(8'h79, 8'h01);
        rd(8'h79, 8'h00);
    endtask : t_zero_limit

    task automatic t_limit();
        int base;
        bus(8'h7A, 1'b1, 8'h03);
        rd(8'h7A, 8'h03);
        base = n_irq;
        throttle(12'd6);
        rd(8'h79, 8'h01);
        cmp("irq", 12'd0, 12'(n_irq - base));
        throttle(12'd22);
        cmp("irq", 12'd1, 12'(n_irq - base));
        rd(8'h79, 8'h05);
    endtask : t_limit

    task automatic t_saturate();
        int base;
        bus(8'h7A, 1'b1, 8'hFF);
        base = n_irq;
        throttle(12'd1100);
        rd(8'h79, 8'hFF);
        cmp("irq", 12'd0, 12'(n_irq - base));
    endtask : t_saturate

    task automatic t_midrun_reset();
        rst_i = 1'b1;
        repeat (2) @(posedge mclk_i);
        #2 rst_i = 1'b0;
        t_reset();
    endtask : t_midrun_reset

    initial
    begin
        repeat (3) @(posedge mclk_i);
        #2 rst_i = 1'b0;
        t_reset();
        t_pulses();
        t_zero_limit();
        t_limit();
        t_saturate();
        t_midrun_reset();
        end_sim();
    end
endmodule : thermal_throttle_pin_assert_timer_tb

`default_nettype wire

// ### tb/throttle_source.sv
// Model of the external thermal-throttle signal that drives the timer's input.
`timescale 1ns/1ps
`default_nettype none

module throttle_source
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Start strobe and length of the assertion in clock cycles.
    input wire logic start_i,
    input wire logic [11:0] len_i,
    // Throttle line, low while asserted.
    output logic thermal_throttle_pin_n_o
);
    logic [11:0] left;

    // The line is held low for exactly the requested number of cycles.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            left <= 12'h000;
        else if (start_i)
            left <= len_i;
        else if (left != 12'h000)
            left <= left - 12'h001;
    end

    assign thermal_throttle_pin_n_o = (left == 12'h000);
endmodule : throttle_source

`default_nettype wire
